// file: radio_power_reset_sequencer.sv
// design: power and reset sequencer for the two radio sections
// Overview of operation
// - The regulators are enabled whenever either power-on input is high.
// - The wireless LAN section stays in reset while its power-on input is low.
// - With both power-on inputs low the regulators are disabled.
// - Short-range input low with LAN input high holds that section in reset.
// - The power-on reset interval holds both sections in reset for the first 110 ms.
`timescale 1ns/1ps
`default_nettype none

module radio_power_reset_sequencer
  import radio_power_reset_pkg::*;
#(
  parameter int unsigned PorCount    = PorCycles,
  parameter int unsigned OffCount    = OffCycles,
  parameter int unsigned AccessCount = AccessCycles
) (
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  wlan_power_on_in,
  input  wire logic                                  shortrange_power_on_in,
  output var  radio_power_reset_pkg::section_ctrl_type sectionCtrl,
  output var  radio_power_reset_pkg::seq_status_type   seqStatus
);
  import radio_power_reset_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // both start low: a pin already high reads as a fresh rise
  logic [1:0] wlanSync_q;
  logic [1:0] srSync_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wlanSync_q <= 2'h0;
      srSync_q   <= 2'h0;
    end else begin
      wlanSync_q <= {wlanSync_q[0], wlan_power_on_in};
      srSync_q   <= {srSync_q[0], shortrange_power_on_in};
    end
  end

  logic wlanOn;
  logic srOn;
  logic anyOn;
  assign wlanOn = wlanSync_q[1];
  assign srOn   = srSync_q[1];
  assign anyOn  = wlanOn | srOn;

  // ----------------------------------------------------------------------
  // counter helpers
  // ----------------------------------------------------------------------
  // one place decides when a count has run out
  function automatic logic countReached(
    input logic [CountWidth-1:0] cnt,
    input int unsigned           lim
  );
    return (cnt >= CountWidth'(lim));
  endfunction

  // saturating, so a long idle spell cannot wrap back into the window
  function automatic logic [CountWidth-1:0] satInc(
    input logic [CountWidth-1:0] cnt,
    input int unsigned           lim
  );
    if (countReached(cnt, lim)) begin
      return cnt;
    end
    return cnt + CountWidth'(1);
  endfunction

  // a section leaves reset only when all three terms hold
  function automatic logic sectionRelease(
    input logic porEnded,
    input logic regulatorOn,
    input logic sectionOn
  );
    return porEnded & regulatorOn & sectionOn;
  endfunction

  // ----------------------------------------------------------------------
  // power-on reset interval
  // ----------------------------------------------------------------------
  // runs from reset release; the supply threshold is rst_n itself
  logic [CountWidth-1:0] porCnt_q;
  logic                  porDone;
  assign porDone = countReached(porCnt_q, PorCount);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      porCnt_q <= '0;
    end else begin
      porCnt_q <= satInc(porCnt_q, PorCount);
    end
  end

  // ----------------------------------------------------------------------
  // access wait monitor
  // ----------------------------------------------------------------------
  // counts from reset release only; the inputs never restart it
  logic [CountWidth-1:0] accCnt_q;
  logic                  accessDone;
  assign accessDone = countReached(accCnt_q, AccessCount);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accCnt_q <= '0;
    end else begin
      accCnt_q <= satInc(accCnt_q, AccessCount);
    end
  end

  // ----------------------------------------------------------------------
  // off interval state
  // ----------------------------------------------------------------------
  power_state_type       state_q;
  power_state_type       state_d;
  logic [CountWidth-1:0] offCnt_q;
  logic                  offMet;
  logic                  violation_q;
  assign offMet = countReached(offCnt_q, OffCount);

  // the off interval is judged only once por has ended
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PowerHold: begin
        if (porDone) begin
          state_d = anyOn ? PowerOn : PowerOff;
        end
      end
      PowerOff: begin
        if (anyOn) begin
          state_d = PowerOn;
        end
      end
      PowerOn: begin
        if (!anyOn) begin
          state_d = PowerOff;
        end
      end
      default: state_d = PowerHold;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PowerHold;
    end else begin
      state_q <= state_d;
    end
  end

  // counts the off time; longer waits simply saturate
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      offCnt_q <= '0;
    end else if (anyOn) begin
      offCnt_q <= '0;
    end else begin
      offCnt_q <= satInc(offCnt_q, OffCount);
    end
  end

  // sticky flag: a rise before the buck has discharged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      violation_q <= 1'b0;
    end else if (state_q == PowerOff && anyOn && !offMet) begin
      violation_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // section control
  // ----------------------------------------------------------------------
  section_ctrl_type sectionCtrl_d;

  always_comb begin
    sectionCtrl_d.regulatorEnable = anyOn;
    sectionCtrl_d.wlanResetN =
      sectionRelease(porDone, anyOn, wlanOn);
    sectionCtrl_d.shortrangeResetN =
      sectionRelease(porDone, anyOn, srOn);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sectionCtrl <= '0;
    end else begin
      sectionCtrl <= sectionCtrl_d;
    end
  end

  // ----------------------------------------------------------------------
  // status
  // ----------------------------------------------------------------------
  // informational only: a violation never blocks the power-up
  seq_status_type seqStatus_d;

  always_comb begin
    seqStatus_d.porDone        = porDone;
    seqStatus_d.offIntervalMet = offMet;
    seqStatus_d.accessReady    = accessDone;
    seqStatus_d.offViolation   = violation_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seqStatus <= '0;
    end else begin
      seqStatus <= seqStatus_d;
    end
  end

endmodule

`default_nettype wire

// file: radio_power_reset_pkg.sv
// package: constants and types for the radio power and reset sequencer
package radio_power_reset_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned ClockHz         = 100_000_000;
  localparam int unsigned PorReleaseMs    = 110;
  localparam int unsigned OffIntervalMs   = 10;
  localparam int unsigned AccessWaitMs    = 150;
  // longest time rounds down
  localparam int unsigned PorCycles       = PorReleaseMs * (ClockHz / 1000);
  // least times also round down
  localparam int unsigned OffCycles       = OffIntervalMs * (ClockHz / 1000);
  localparam int unsigned AccessCycles    = AccessWaitMs * (ClockHz / 1000);
  localparam int unsigned CountWidth      = 25;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PowerHold  = 2'b00,
    PowerOff   = 2'b01,
    PowerOn    = 2'b10
  } power_state_type;

  typedef struct packed {
    logic regulatorEnable;
    logic wlanResetN;
    logic shortrangeResetN;
  } section_ctrl_type;

  typedef struct packed {
    logic porDone;
    logic offIntervalMet;
    logic accessReady;
    logic offViolation;
  } seq_status_type;

endpackage

// file: radio_power_monitor.sv
// checker for the radio power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module radio_power_monitor
  import radio_power_reset_pkg::*;
#(parameter int unsigned PorCount = 50) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             wlan_power_on_in,
  input wire logic             shortrange_power_on_in,
  input wire section_ctrl_type sectionCtrl,
  input wire seq_status_type   seqStatus
);
  // ----
  // helpers and assertions
  // ----
  logic w, s, up;
  int   cnt;
  assign w = wlan_power_on_in;
  assign s = shortrange_power_on_in;
  // margin covers sync flops and the output lag
  assign up = cnt >= PorCount + 5;
  // saturates so a long run cannot wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else if (cnt < PorCount + 9) cnt <= cnt + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reg_on: assert property ((up && (w || s))[*4] |-> sectionCtrl[2])
    else $error("regulator off with an input high");
  a_reg_off: assert property ((up && !w && !s)[*4] |-> !sectionCtrl[2])
    else $error("regulator on with both inputs low");
  a_wlan_held: assert property ((!w)[*4] |-> !sectionCtrl[1])
    else $error("lan section free with input low");
  a_wlan_free: assert property ((up && w)[*4] |-> sectionCtrl[1])
    else $error("lan section held with input high");
  a_short_held: assert property ((!s)[*4] |-> !sectionCtrl[0])
    else $error("short-range section free with input low");
  a_short_free: assert property ((up && s)[*4] |-> sectionCtrl[0])
    else $error("short-range section held with input high");
  a_por_hold: assert property (cnt <= PorCount |-> !(|sectionCtrl[1:0]))
    else $error("section released inside the reset interval");
  a_por_done: assert property (cnt > PorCount |-> seqStatus.porDone)
    else $error("reset interval not ended in time");
  a_viol_sticky: assert property (
    seqStatus.offViolation |=> seqStatus.offViolation)
    else $error("off violation flag cleared without reset");
endmodule
bind radio_power_reset_sequencer radio_power_monitor #(.PorCount(PorCount))
  u_radio_power_monitor (.sys_clk, .rst_n, .wlan_power_on_in,
  .shortrange_power_on_in, .sectionCtrl, .seqStatus);
`default_nettype wire

// file: radio_host_model.sv
// host model that drives the two power-on levels
`timescale 1ns/1ps
`default_nettype none
module radio_host_model #(parameter int unsigned OffCount = 10) (
  input  wire logic sys_clk,
  input  wire logic wantWlan,
  input  wire logic wantShort,
  input  wire logic hurry,
  output var  logic wlanPin,
  output var  logic shortPin
);
  // ----
  // pins follow requests, rises held back
  // ----
  int   lowCnt = OffCount;
  logic ok, w, s;
  initial begin
    wlanPin = 1'b0;
    shortPin = 1'b0;
    forever begin
      @(posedge sys_clk);
      {w, s} = {wantWlan, wantShort};
      // early rise only when told: in-rush risk
      ok = hurry || wlanPin || shortPin || lowCnt >= OffCount;
      #1;
      if (ok || !w) wlanPin = w;
      if (ok || !s) shortPin = s;
      lowCnt = (wlanPin || shortPin) ? 0 : lowCnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: tb.sv
// testbench for the radio power and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import radio_power_reset_pkg::*;
  // ----
  // bench
  // ----
  localparam int unsigned Por = 50;
  localparam int unsigned Off = 10;
  localparam int unsigned Acc = 70;
  localparam logic [1:0] Modes [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h1};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wantWlan = 1'b0;
  logic wantShort = 1'b0;
  logic hurry = 1'b0;
  logic wlanPin, shortPin;
  section_ctrl_type sectionCtrl;
  seq_status_type   seqStatus;
  int num_errors = 0;
  int checks = 0;
  radio_host_model #(.OffCount(Off)) u_radio_host_model (.sys_clk,
    .wantWlan, .wantShort, .hurry, .wlanPin, .shortPin);
  radio_power_reset_sequencer #(.PorCount(Por), .OffCount(Off),
    .AccessCount(Acc)) u_radio_power_reset_sequencer (.sys_clk, .rst_n,
    .wlan_power_on_in(wlanPin), .shortrange_power_on_in(shortPin),
    .sectionCtrl, .seqStatus);
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_por();
    {wantWlan, wantShort} = 2'h3;
    cycles(Por - 5);
    check("held", {2'h0, sectionCtrl[1:0]}, 4'h0);
    check("held status", seqStatus, 4'h0);
    cycles(13);
    check("released", {1'b0, sectionCtrl}, 4'h7);
    check("released status", seqStatus, 4'h8);
  endtask
  task automatic t_modes();
    logic [3:0] want;
    logic [3:0] seen;
    foreach (Modes[i]) begin
      {wantWlan, wantShort} = Modes[i];
      // settles well past the off interval
      cycles(Off + 10);
      // off interval met only after the all-low mode
      want = {|Modes[i], Modes[i], Modes[i] == 2'h0};
      seen = {sectionCtrl, seqStatus.offIntervalMet};
      check("mode", seen, want);
    end
    check("status", seqStatus, 4'hA);
  endtask
  task automatic t_hurry();
    {wantWlan, wantShort} = 2'h0;
    cycles(4);
    hurry = 1'b1;
    wantWlan = 1'b1;
    cycles(8);
    check("early", {2'h0, seqStatus.offViolation, sectionCtrl[1]}, 4'h3);
    hurry = 1'b0;
  endtask
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    cycles(5);
    rst_n = 1'b1;
    t_por();
    t_modes();
    t_hurry();
    rst_n = 1'b0;
    cycles(2);
    check("reset", {sectionCtrl, seqStatus.offViolation}, 4'h0);
    rst_n = 1'b1;
    t_por();
    print_verdict();
  end
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
